// [mesx_map.svh]
// Register offsets, field positions and reset values of the skip and arithmetic execution block.
`ifndef MESX_MAP_SVH
`define MESX_MAP_SVH
`define MESX_OFS_INSTR     8'h00
`define MESX_OFS_STATUS    8'h04
`define MESX_OFS_ACC       8'h08
`define MESX_OFS_FLAGS     8'h0c
`define MESX_OFS_TPTR      8'h10
`define MESX_OFS_THIGH     8'h14
`define MESX_OFS_PC        8'h18
`define MESX_OFS_DADDR     8'h1c
`define MESX_OFS_DDATA     8'h20
`define MESX_OFS_PADDR     8'h24
`define MESX_OFS_PDATA     8'h28
`define MESX_INSTR_OP_LSB  0
`define MESX_INSTR_AD_LSB  8
`define MESX_INSTR_BIT_LSB 16
`define MESX_INSTR_IMM_LSB 24
`define MESX_ST_BUSY       0
`define MESX_ST_SKIP       1
`define MESX_RST_ACC       8'h00
`define MESX_RST_FLAGS     4'h0
`define MESX_RST_TPTR      8'h00
`define MESX_RST_PC        10'h000
`define MESX_STEP_ONE      10'h001
`define MESX_STEP_TWO      10'h002
`endif

// [mesx_pkg.sv]
// Types shared by the skip and arithmetic execution block.
package mesx_pkg;
	typedef enum logic [4:0] {
		MESX_NOP                     = 5'h00,
		MESX_DEC_TO_ACC_SKIP_ZERO    = 5'h01,
		MESX_FILL_ONES               = 5'h02,
		MESX_BIT_RAISE               = 5'h03,
		MESX_INC_SKIP_ZERO           = 5'h04,
		MESX_INC_TO_ACC_SKIP_ZERO    = 5'h05,
		MESX_BIT_ONE_SKIP            = 5'h06,
		MESX_MINUS_ACC_OP            = 5'h07,
		MESX_MINUS_TO_MEM_OP         = 5'h08,
		MESX_MINUS_IMM_OP            = 5'h09,
		MESX_NIBBLE_EXCHANGE         = 5'h0a,
		MESX_NIBBLE_EXCHANGE_TO_ACC  = 5'h0b,
		MESX_ZERO_TEST_SKIP          = 5'h0c,
		MESX_MOVE_AND_ZERO_SKIP      = 5'h0d,
		MESX_BIT_ZERO_SKIP           = 5'h0e,
		MESX_TABLE_READ_CURRENT_PAGE = 5'h0f,
		MESX_TABLE_READ_LAST_PAGE    = 5'h10,
		MESX_EXCLUSIVE_OR_ACC_OP     = 5'h11,
		MESX_EXCLUSIVE_OR_TO_MEM_OP  = 5'h12,
		MESX_EXCLUSIVE_OR_IMM_OP     = 5'h13
	} mesx_op_type;

	typedef enum logic [1:0] {
		MESX_IDLE  = 2'b00,
		MESX_EXEC  = 2'b01,
		MESX_DUMMY = 2'b10
	} mesx_state_type;

	typedef struct packed {
		logic       ov;
		logic       z;
		logic       ac;
		logic       c;
	} mesx_flags_type;

	typedef struct packed {
		logic [7:0] imm;
		logic [4:0] pad2;
		logic [2:0] bit_sel;
		logic [1:0] pad1;
		logic [5:0] addr;
		logic [2:0] pad0;
		logic [4:0] op;
	} mesx_instr_type;

	typedef struct packed {
		logic [7:0]     res;
		logic           mem_we;
		logic           acc_we;
		logic           thigh_we;
		logic           skip;
		mesx_flags_type fl;
		logic [3:0]     fl_we;
	} mesx_result_type;
endpackage

// [mesx_exec.sv]
// Execution unit for skips, bit set, subtraction, nibble swap, table read and exclusive-or.
//
// Added by the designer: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
`include "mesx_map.svh"
module mesx_exec
	import mesx_pkg::*;
#(
	parameter int DM_AW = 6,
	parameter int PC_W  = 10,
	parameter int PW    = 14
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             busy_o,
	output logic             skip_o
);
	logic [7:0]      dmem [0:(1<<DM_AW)-1];
	logic [PW-1:0]   pmem [0:(1<<PC_W)-1];

	mesx_state_type  state_q;
	mesx_state_type  state_d;
	mesx_instr_type  instr_q;
	mesx_flags_type  flags_q;
	logic [7:0]      acc_q;
	logic [7:0]      tptr_q;
	logic [PW-9:0]   thigh_q;
	logic [PC_W-1:0] pc_q;
	logic [DM_AW-1:0] daddr_q;
	logic [PC_W-1:0] paddr_q;
	logic            skip_q;
	logic            ack_q;
	logic [31:0]     rdat_q;

	function automatic logic [31:0] lane_mask(input logic [3:0] sel);
		lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		merge = (old & ~lane_mask(sel)) | (nw & lane_mask(sel));
	endfunction

	// Two's complement subtract a - b as a + ~b + 1 with all four flags.
	function automatic mesx_result_type minus(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] full;
		logic [4:0] low;
		logic [7:0] mid;
		mesx_result_type r;
		full = {1'b0, a} + {1'b0, ~b} + 9'h001;
		low = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
		mid = {1'b0, a[6:0]} + {1'b0, ~b[6:0]} + 8'h01;
		r = '0;
		r.res = full[7:0];
		r.fl.c = full[8];
		r.fl.ac = low[4];
		r.fl.ov = mid[7] ^ full[8];
		r.fl.z = (full[7:0] == 8'h00);
		minus = r;
	endfunction

	// Bus decode.
	wire        bus_req   = wb_cyc_i & wb_stb_i & ~ack_q & (state_q == MESX_IDLE);
	wire        bus_wr    = bus_req & wb_we_i;
	wire [31:0] wr_instr  = merge(32'h0, wb_dat_i, wb_sel_i);
	wire        go        = bus_wr & (wb_adr_i == `MESX_OFS_INSTR);
	wire        wr_acc    = bus_wr & (wb_adr_i == `MESX_OFS_ACC) & wb_sel_i[0];
	wire        wr_flags  = bus_wr & (wb_adr_i == `MESX_OFS_FLAGS) & wb_sel_i[0];
	wire        wr_tptr   = bus_wr & (wb_adr_i == `MESX_OFS_TPTR) & wb_sel_i[0];
	wire        wr_pc     = bus_wr & (wb_adr_i == `MESX_OFS_PC);
	wire        wr_daddr  = bus_wr & (wb_adr_i == `MESX_OFS_DADDR) & wb_sel_i[0];
	wire        wr_ddata  = bus_wr & (wb_adr_i == `MESX_OFS_DDATA) & wb_sel_i[0];
	wire        wr_paddr  = bus_wr & (wb_adr_i == `MESX_OFS_PADDR);
	wire        wr_pdata  = bus_wr & (wb_adr_i == `MESX_OFS_PDATA);
	wire [31:0] pc_merged = merge({{(32-PC_W){1'b0}}, pc_q}, wb_dat_i, wb_sel_i);
	wire [31:0] pa_merged = merge({{(32-PC_W){1'b0}}, paddr_q}, wb_dat_i, wb_sel_i);
	wire [31:0] pd_merged = merge({{(32-PW){1'b0}}, pmem[paddr_q]}, wb_dat_i, wb_sel_i);

	// Operand fetch.
	wire [7:0]      opnd     = dmem[instr_q.addr];
	wire [7:0]      bit_mask = 8'h01 << instr_q.bit_sel;
	wire            bit_val  = |(opnd & bit_mask);
	wire [7:0]      dec_val  = opnd - 8'h01;
	wire [7:0]      inc_val  = opnd + 8'h01;
	wire [7:0]      swapped  = {opnd[3:0], opnd[7:4]};
	wire [7:0]      xm_val   = acc_q ^ opnd;
	wire [7:0]      xi_val   = acc_q ^ instr_q.imm;
	wire [PC_W-1:0] tab_cur  = {pc_q[PC_W-1:8], tptr_q};
	wire [PC_W-1:0] tab_last = {{(PC_W-8){1'b1}}, tptr_q};
	wire [PW-1:0]   tab_word = (mesx_op_type'(instr_q.op) == MESX_TABLE_READ_LAST_PAGE)
		? pmem[tab_last] : pmem[tab_cur];
	wire mesx_result_type sub_m = minus(acc_q, opnd);
	wire mesx_result_type sub_i = minus(acc_q, instr_q.imm);

	mesx_result_type ex;

	always_comb begin
		ex = '0;
		unique case (mesx_op_type'(instr_q.op))
			MESX_DEC_TO_ACC_SKIP_ZERO: begin
				ex.res = dec_val;
				ex.acc_we = 1'b1;
				ex.skip = (dec_val == 8'h00);
			end
			MESX_FILL_ONES: begin
				ex.res = 8'hff;
				ex.mem_we = 1'b1;
			end
			MESX_BIT_RAISE: begin
				ex.res = opnd | bit_mask;
				ex.mem_we = 1'b1;
			end
			MESX_INC_SKIP_ZERO: begin
				ex.res = inc_val;
				ex.mem_we = 1'b1;
				ex.skip = (inc_val == 8'h00);
			end
			MESX_INC_TO_ACC_SKIP_ZERO: begin
				ex.res = inc_val;
				ex.acc_we = 1'b1;
				ex.skip = (inc_val == 8'h00);
			end
			MESX_BIT_ONE_SKIP: begin
				ex.skip = bit_val;
			end
			MESX_MINUS_ACC_OP: begin
				ex = sub_m;
				ex.acc_we = 1'b1;
				ex.fl_we = 4'hf;
			end
			MESX_MINUS_TO_MEM_OP: begin
				ex = sub_m;
				ex.mem_we = 1'b1;
				ex.fl_we = 4'hf;
			end
			MESX_MINUS_IMM_OP: begin
				ex = sub_i;
				ex.acc_we = 1'b1;
				ex.fl_we = 4'hd;
			end
			MESX_NIBBLE_EXCHANGE: begin
				ex.res = swapped;
				ex.mem_we = 1'b1;
			end
			MESX_NIBBLE_EXCHANGE_TO_ACC: begin
				ex.res = swapped;
				ex.acc_we = 1'b1;
			end
			MESX_ZERO_TEST_SKIP: begin
				ex.skip = (opnd == 8'h00);
			end
			MESX_MOVE_AND_ZERO_SKIP: begin
				ex.res = opnd;
				ex.acc_we = 1'b1;
				ex.skip = (opnd == 8'h00);
			end
			MESX_BIT_ZERO_SKIP: begin
				ex.skip = ~bit_val;
			end
			MESX_TABLE_READ_CURRENT_PAGE, MESX_TABLE_READ_LAST_PAGE: begin
				ex.res = tab_word[7:0];
				ex.mem_we = 1'b1;
				ex.thigh_we = 1'b1;
			end
			MESX_EXCLUSIVE_OR_ACC_OP: begin
				ex.res = xm_val;
				ex.acc_we = 1'b1;
				ex.fl.z = (xm_val == 8'h00);
				ex.fl_we = 4'h4;
			end
			MESX_EXCLUSIVE_OR_TO_MEM_OP: begin
				ex.res = xm_val;
				ex.mem_we = 1'b1;
				ex.fl.z = (xm_val == 8'h00);
				ex.fl_we = 4'h4;
			end
			MESX_EXCLUSIVE_OR_IMM_OP: begin
				ex.res = xi_val;
				ex.acc_we = 1'b1;
				ex.fl.z = (xi_val == 8'h00);
				ex.fl_we = 4'h4;
			end
			default: begin
				ex = '0;
			end
		endcase
	end

	wire             in_exec = (state_q == MESX_EXEC);
	wire             dm_we   = (in_exec & ex.mem_we) | wr_ddata;
	wire [DM_AW-1:0] dm_wa   = in_exec ? instr_q.addr : daddr_q;
	wire [7:0]       dm_wd   = in_exec ? ex.res : wb_dat_i[7:0];
	wire [3:0]       fl_old  = flags_q;
	wire [3:0]       fl_new  = (fl_old & ~ex.fl_we) | (ex.fl & ex.fl_we);

	// A met skip adds one dummy cycle and steps the counter past the fetched word.
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			MESX_IDLE:  state_d = go ? MESX_EXEC : MESX_IDLE;
			MESX_EXEC:  state_d = ex.skip ? MESX_DUMMY : MESX_IDLE;
			MESX_DUMMY: state_d = MESX_IDLE;
			default:    state_d = MESX_IDLE;
		endcase
	end

	// Read data selection.
	logic [31:0] rd_d;
	always_comb begin
		rd_d = 32'h0;
		unique case (wb_adr_i)
			`MESX_OFS_INSTR:  rd_d = instr_q;
			`MESX_OFS_STATUS: rd_d = {30'h0, skip_q, 1'b0};
			`MESX_OFS_ACC:    rd_d = {24'h0, acc_q};
			`MESX_OFS_FLAGS:  rd_d = {28'h0, flags_q};
			`MESX_OFS_TPTR:   rd_d = {24'h0, tptr_q};
			`MESX_OFS_THIGH:  rd_d = {{(32-(PW-8)){1'b0}}, thigh_q};
			`MESX_OFS_PC:     rd_d = {{(32-PC_W){1'b0}}, pc_q};
			`MESX_OFS_DADDR:  rd_d = {{(32-DM_AW){1'b0}}, daddr_q};
			`MESX_OFS_DDATA:  rd_d = {24'h0, dmem[daddr_q]};
			`MESX_OFS_PADDR:  rd_d = {{(32-PC_W){1'b0}}, paddr_q};
			`MESX_OFS_PDATA:  rd_d = {{(32-PW){1'b0}}, pmem[paddr_q]};
			default:          rd_d = 32'h0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (dm_we) begin
			dmem[dm_wa] <= dm_wd;
		end
		if (wr_pdata) begin
			pmem[paddr_q] <= pd_merged[PW-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q  <= 1'b0;
			rdat_q <= 32'h0;
		end else begin
			ack_q  <= bus_req;
			rdat_q <= bus_req ? rd_d : 32'h0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= MESX_IDLE;
			instr_q <= '0;
			skip_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			if (go) begin
				instr_q <= mesx_instr_type'(wr_instr);
			end
			if (in_exec) begin
				skip_q <= ex.skip;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			acc_q   <= `MESX_RST_ACC;
			flags_q <= `MESX_RST_FLAGS;
			thigh_q <= '0;
		end else if (in_exec) begin
			if (ex.acc_we) begin
				acc_q <= ex.res;
			end
			flags_q <= fl_new;
			if (ex.thigh_we) begin
				thigh_q <= tab_word[PW-1:8];
			end
		end else begin
			if (wr_acc) begin
				acc_q <= wb_dat_i[7:0];
			end
			if (wr_flags) begin
				flags_q <= wb_dat_i[3:0];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pc_q    <= `MESX_RST_PC;
			tptr_q  <= `MESX_RST_TPTR;
			daddr_q <= '0;
			paddr_q <= '0;
		end else begin
			if (in_exec) begin
				pc_q <= pc_q + (ex.skip ? `MESX_STEP_TWO : `MESX_STEP_ONE);
			end else if (wr_pc) begin
				pc_q <= pc_merged[PC_W-1:0];
			end
			if (wr_tptr) begin
				tptr_q <= wb_dat_i[7:0];
			end
			if (wr_daddr) begin
				daddr_q <= wb_dat_i[DM_AW-1:0];
			end
			if (wr_paddr) begin
				paddr_q <= pa_merged[PC_W-1:0];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy_o <= 1'b0;
			skip_o <= 1'b0;
		end else begin
			busy_o <= (state_d != MESX_IDLE);
			skip_o <= in_exec & ex.skip;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;
endmodule
`default_nettype wire

// [mesx_host.sv]
// Wishbone classic master standing in for the software side.
`timescale 1ns/1ns
`default_nettype none
module mesx_host (
	input  wire logic        clk_i,
	input  wire logic [31:0] dat_i,
	input  wire logic        ack_i,
	output logic             cyc_o,
	output logic             stb_o,
	output logic             we_o,
	output logic      [7:0]  adr_o,
	output logic      [3:0]  sel_o,
	output logic      [31:0] dat_o
);
	initial begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o  = 1'b0;
		adr_o = 8'h00;
		sel_o = 4'h0;
		dat_o = 32'h0;
	end

	// Holds the request until ack is seen, then drops it and scrambles the released lines.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o  <= w;
		adr_o <= a;
		dat_o <= d;
		sel_o <= 4'hf;
		do @(posedge clk_i); while (ack_i !== 1'b1);
		q = dat_i;
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		we_o  <= ~w;
		adr_o <= ~a;
		dat_o <= ~d;
		sel_o <= 4'h0;
	endtask
endmodule
`default_nettype wire

// [mesx_exec_sva.sv]
// Port checks of the execution unit.
`timescale 1ns/1ns
`default_nettype none
module mesx_exec_sva (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        busy_o,
	input wire logic        skip_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_one;
		##1 (!busy_o && !skip_o) ##1 !busy_o;
	endsequence
	sequence s_two;
		##1 (busy_o && skip_o) ##1 !busy_o;
	endsequence
	property p_busy_len;
		$rose(busy_o) |-> s_one or s_two;
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
	property p_skip_dummy;
		skip_o |-> busy_o && $past(busy_o);
	endproperty
	a_skip_dummy: assert property (p_skip_dummy) else $error("skip outside dummy");
	property p_skip_pulse;
		skip_o |=> !skip_o;
	endproperty
	a_skip_pulse: assert property (p_skip_pulse) else $error("skip too long");
	property p_start;
		wb_ack_o && wb_we_i && wb_adr_i == 8'h00 |-> busy_o ##1 (busy_o == skip_o);
	endproperty
	a_start: assert property (p_start) else $error("instruction not started");
	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	property p_ack_cause;
		wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	property p_dat_idle;
		!wb_ack_o |-> wb_dat_o == 32'h0;
	endproperty
	a_dat_idle: assert property (p_dat_idle) else $error("read data without ack");
	property p_busy_stall;
		busy_o && !$rose(busy_o) |-> !wb_ack_o;
	endproperty
	a_busy_stall: assert property (p_busy_stall) else $error("ack while busy");
endmodule
bind mesx_exec mesx_exec_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .busy_o(busy_o),
	.skip_o(skip_o));
`default_nettype wire

// [tb.sv]
// Self-checking bench for the execution unit.
`timescale 1ns/1ns
`default_nettype none
`include "mesx_map.svh"
module tb;
	typedef struct packed {
		logic [4:0] op;
		logic [2:0] b;
		logic [7:0] imm, m, a;
		logic [3:0] f;
		logic [7:0] ea, em;
		logic [3:0] ef;
		logic       es;
	} mesx_row_type;
	logic         clk_i;
	logic         rst_i;
	wire          cyc, stb, we, ack, busy, skip;
	wire  [7:0]   adr;
	wire  [3:0]   sel;
	wire  [31:0]  wdat, rdat;
	int           err_count = 0;
	int           checked = 0;
	int           cycles = 0;
	int           busy_seen = 0;
	int           skip_seen = 0;
	int           b0;
	int           s0;
	mesx_row_type r;
	mesx_row_type rows [20] = '{
		'{5'h01, 3'h0, 8'h00, 8'h01, 8'h33, 4'hf, 8'h00, 8'h01, 4'hf, 1'b1},
		'{5'h01, 3'h0, 8'h00, 8'h05, 8'h00, 4'h0, 8'h04, 8'h05, 4'h0, 1'b0},
		'{5'h02, 3'h0, 8'h00, 8'h12, 8'haa, 4'h5, 8'haa, 8'hff, 4'h5, 1'b0},
		'{5'h03, 3'h6, 8'h00, 8'h81, 8'h00, 4'ha, 8'h00, 8'hc1, 4'ha, 1'b0},
		'{5'h04, 3'h0, 8'h00, 8'hff, 8'h11, 4'h0, 8'h11, 8'h00, 4'h0, 1'b1},
		'{5'h04, 3'h0, 8'h00, 8'h7f, 8'h11, 4'h0, 8'h11, 8'h80, 4'h0, 1'b0},
		'{5'h05, 3'h0, 8'h00, 8'hff, 8'h22, 4'h0, 8'h00, 8'hff, 4'h0, 1'b1},
		'{5'h06, 3'h7, 8'h00, 8'h80, 8'h00, 4'h0, 8'h00, 8'h80, 4'h0, 1'b1},
		'{5'h07, 3'h0, 8'h00, 8'h01, 8'h10, 4'h0, 8'h0f, 8'h01, 4'h1, 1'b0},
		'{5'h07, 3'h0, 8'h00, 8'h01, 8'h80, 4'h0, 8'h7f, 8'h01, 4'h9, 1'b0},
		'{5'h08, 3'h0, 8'h00, 8'h05, 8'h05, 4'h0, 8'h05, 8'h00, 4'h7, 1'b0},
		'{5'h09, 3'h0, 8'h01, 8'h00, 8'h00, 4'hf, 8'hff, 8'h00, 4'h2, 1'b0},
		'{5'h0a, 3'h0, 8'h00, 8'h3c, 8'h00, 4'h5, 8'h00, 8'hc3, 4'h5, 1'b0},
		'{5'h0b, 3'h0, 8'h00, 8'ha1, 8'h00, 4'h0, 8'h1a, 8'ha1, 4'h0, 1'b0},
		'{5'h0c, 3'h0, 8'h00, 8'h00, 8'h44, 4'hf, 8'h44, 8'h00, 4'hf, 1'b1},
		'{5'h0d, 3'h0, 8'h00, 8'h00, 8'h55, 4'h0, 8'h00, 8'h00, 4'h0, 1'b1},
		'{5'h0e, 3'h3, 8'h00, 8'h08, 8'h00, 4'h0, 8'h00, 8'h08, 4'h0, 1'b0},
		'{5'h11, 3'h0, 8'h00, 8'h5a, 8'h5a, 4'h0, 8'h00, 8'h5a, 4'h4, 1'b0},
		'{5'h12, 3'h0, 8'h00, 8'h0f, 8'hff, 4'hf, 8'hff, 8'hf0, 4'hb, 1'b0},
		'{5'h13, 3'h0, 8'hc3, 8'h00, 8'hc3, 4'h0, 8'h00, 8'h00, 4'h4, 1'b0}
	};

	mesx_host host (.clk_i(clk_i), .dat_i(rdat), .ack_i(ack), .cyc_o(cyc), .stb_o(stb),
		.we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
	mesx_exec uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .busy_o(busy), .skip_o(skip));

	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	task automatic tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	always @(posedge clk_i) begin
		cycles++;
		if (busy === 1'b1) begin
			busy_seen++;
		end
		if (skip === 1'b1) begin
			skip_seen++;
		end
		if (cycles == 20000) begin
			err_count++;
			tally_and_finish();
		end
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		host.xfer(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		host.xfer(1'b0, a, 32'h0, q);
		checked++;
		if (q !== e) begin
			err_count++;
			$display("CHECK FAILED at %0t: addr %h got %h expected %h", $time, a, q, e);
		end
	endtask

	initial begin
		rst_i = 1'b1;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(`MESX_OFS_ACC, 32'h0);
		rd(`MESX_OFS_FLAGS, 32'h0);
		rd(`MESX_OFS_PC, 32'h0);
		rd(`MESX_OFS_TPTR, 32'h0);
		for (int i = 0; i < 20; i++) begin
			r = rows[i];
			wr(`MESX_OFS_DADDR, 32'h5);
			wr(`MESX_OFS_DDATA, {24'h0, r.m});
			wr(`MESX_OFS_ACC, {24'h0, r.a});
			wr(`MESX_OFS_FLAGS, {28'h0, r.f});
			wr(`MESX_OFS_PC, 32'h0);
			b0 = busy_seen;
			s0 = skip_seen;
			wr(`MESX_OFS_INSTR, {r.imm, 5'h00, r.b, 2'h0, 6'h05, 3'h0, r.op});
			rd(`MESX_OFS_STATUS, {30'h0, r.es, 1'b0});
			checked++;
			if (busy_seen - b0 != (r.es ? 2 : 1) || skip_seen - s0 != r.es) begin
				err_count++;
				$display("CHECK FAILED at %0t: busy %0d skip %0d", $time,
					busy_seen - b0, skip_seen - s0);
			end
			rd(`MESX_OFS_PC, r.es ? 32'h2 : 32'h1);
			rd(`MESX_OFS_ACC, {24'h0, r.ea});
			rd(`MESX_OFS_FLAGS, {28'h0, r.ef});
			rd(`MESX_OFS_DDATA, {24'h0, r.em});
		end
		wr(`MESX_OFS_PADDR, 32'h134);
		wr(`MESX_OFS_PDATA, 32'h2a5b);
		wr(`MESX_OFS_PADDR, 32'h334);
		wr(`MESX_OFS_PDATA, 32'h1c77);
		wr(`MESX_OFS_TPTR, 32'h34);
		wr(`MESX_OFS_FLAGS, 32'h5);
		wr(`MESX_OFS_PC, 32'h120);
		wr(`MESX_OFS_INSTR, 32'h0000050f);
		rd(`MESX_OFS_DDATA, 32'h5b);
		rd(`MESX_OFS_THIGH, 32'h2a);
		wr(`MESX_OFS_INSTR, 32'h00000510);
		rd(`MESX_OFS_DDATA, 32'h77);
		rd(`MESX_OFS_THIGH, 32'h1c);
		rd(`MESX_OFS_FLAGS, 32'h5);
		wr(`MESX_OFS_PC, 32'h10);
		wr(`MESX_OFS_INSTR, 32'h00000500);
		rd(`MESX_OFS_PC, 32'h11);
		rd(`MESX_OFS_STATUS, 32'h0);
		rd(`MESX_OFS_DDATA, 32'h77);
		rd(`MESX_OFS_FLAGS, 32'h5);
		wr(8'h40, 32'hff);
		rd(8'h40, 32'h0);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(`MESX_OFS_ACC, 32'h0);
		rd(`MESX_OFS_PC, 32'h0);
		rd(`MESX_OFS_FLAGS, 32'h0);
		rd(`MESX_OFS_THIGH, 32'h0);
		tally_and_finish();
	end
endmodule
`default_nettype wire
